// ### scaler_pkg.sv
// Summary of operation
// R1 - Synchronise input, count each rising edge once.
// R2 - Counters are 28 bits and wrap.
// R3 - One enable bit per 32-channel block.
// R4 - Hardware or software clear zeroes counters.
// R5 - Hardware clear acts only where enabled.
// R6 - Operator avoids clears near a trigger.
// R7 - Count only while window gate high.
// R8 - Window gate defaults high, selectable input.
// R9 - Output selector codes pick output sources.
// R10 - Crate busy ORs module, backplane, external busy.
// R11 - Input codes 0-3 pick inputs, 7 default.
// R12 - Reset routing follows default assignments.
// R13 - Self busy lasts 210 ns per trigger.
// R14 - First header word is fixed magic.
// R15 - Second header carries body word count.
// R16 - Third header: receiver bit, tag, counter.
// R17 - Tag from event and spill numbers.
// R18 - Local event counter counts forwarded events.
// R19 - Receiver word layout with lock bit set.
// R20 - Counter word: block code, 28-bit count.
// R21 - Block codes 0x8 to 0xB.
// R22 - Body holds receiver word when present.
// R23 - Trigger latches all counters for readout.
// R24 - Enable bits map blocks in fixed order.
// R25 - Clear command write gives one-cycle pulse.
package scaler_pkg;
  localparam int          CLK_MHZ     = 250;
  localparam int          SELF_BUSY_NS = 210;
  localparam int          SELF_BUSY_CYC = (SELF_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int          PRESCALE    = CLK_MHZ;
  localparam int          NUM_BLOCKS  = 4;
  localparam int          BLOCK_CH    = 32;
  localparam int          CNT_W       = 28;
  // Magic word value is arbitrary.
  localparam logic [31:0] MAGIC_WORD  = 32'h5CA1E001;
  localparam logic [7:0]  HDR_MARK    = 8'hFF;
  localparam logic [7:0]  RECV_MARK   = 8'hF9;
  localparam logic [3:0]  BLOCK_CODE0 = 4'h8;
  localparam logic [7:0]  A_CLEAR     = 8'h00;
  localparam logic [7:0]  A_BLK_EN    = 8'h04;
  localparam logic [7:0]  A_HW_EN     = 8'h08;
  localparam logic [7:0]  A_ACQ_GATE  = 8'h0C;
  localparam logic [7:0]  A_OUTSEL0   = 8'h10;
  localparam logic [7:0]  A_INSEL0    = 8'h20;
  localparam logic [7:0]  A_STATUS    = 8'h3C;
  localparam logic [3:0]  BLK_EN_RST  = 4'hF;
  localparam logic [3:0]  HW_EN_RST   = 4'hF;
  localparam logic [15:0] OUTSEL_RST  = 16'h8C70;
  localparam logic [20:0] INSEL_RST   = 21'h0D1FF8;
  localparam logic [2:0]  IN_DEFAULT  = 3'h7;
  localparam int          IN_L1 = 0, IN_L2 = 1, IN_CLR = 2, IN_GATE = 3, IN_CCLR = 4, IN_BUSY = 5, IN_SPARE = 6;

  typedef struct packed {
    logic        level1;
    logic        level2;
    logic        clear;
    logic        spare1;
    logic        spill_inc;
    logic [7:0]  spill_num;
    logic [11:0] event_num;
  } rx_info_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } evt_word_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_RECV = 2'b10,
    ST_CNT  = 2'b11
  } evt_state_e;
endpackage : scaler_pkg

// ### scaler_top.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module scaler_top #(
  parameter int NCH = 128
) (
  input  wire logic                 clk_sys,       // System clock.
  input  wire logic                 nrst,          // Asynchronous reset, active low.
  input  wire logic [7:0]           addr,          // Register byte address.
  input  wire logic [31:0]          wdata,         // Register write data.
  input  wire logic                 wr,            // Write strobe.
  input  wire logic                 rd,            // Read strobe.
  output logic [31:0]               rdata,         // Read data, cycle after rd.
  input  wire logic [NCH-1:0]       hit_in,        // Detector pulses.
  input  wire logic [3:0]           nim_in,        // NIM inputs 1 to 4.
  input  wire logic [7:0]           switch_in,     // Switch channels 1 to 8.
  input  wire logic                 backplane_busy, // Busy from backplane bus.
  input  wire scaler_pkg::rx_info_s rx_info,       // Trigger receiver signals.
  input  wire logic                 evt_ready,     // Event builder accepts word.
  output scaler_pkg::evt_word_s     evt_out,       // Event word stream.
  output logic [3:0]                nim_out,       // NIM outputs 1 to 4.
  output logic [2:0]                route_out,     // Routed level2, clear, spare2.
  output logic                      module_busy    // Module busy level.
);
  localparam int DLY = scaler_pkg::SELF_BUSY_CYC;
  // Self busy is high on DLY edges after the take; the check lands on the first low edge.
  localparam int BUSY_TAIL = DLY - 7;

  logic [NCH-1:0]  sync1_reg, sync2_reg, sync3_reg;
  logic [27:0]     cnt_reg  [NCH];
  logic [27:0]     snap_reg [NCH];
  logic [3:0]      blk_en_reg, hw_en_reg, en_lat_reg;
  logic            acq_gate_reg, sw_clr_reg;
  logic [3:0]      outsel_reg [4];
  logic [2:0]      insel_reg [7];
  logic [6:0]      routed_reg;
  logic [31:0]     rdata_reg;
  logic            l1_prev_reg, present_reg, self_busy_reg, module_busy_reg, crate_busy_reg;
  logic [7:0]      busy_cnt_reg;
  logic [3:0]      nim_out_reg;
  logic [10:0]     nwords_reg;
  logic [15:0]     lcl_cnt_reg;
  scaler_pkg::rx_info_s  rx_lat_reg;
  scaler_pkg::evt_word_s evt_reg;
  scaler_pkg::evt_state_e st_reg;
  logic [1:0]      hd_reg;
  logic [6:0]      ch_reg;
  logic [7:0]      pres_reg;
  logic [3:0]      dec_reg [3];

  // Register decode.
  wire        wr_clr   = wr && addr == scaler_pkg::A_CLEAR;
  wire        wr_blk   = wr && addr == scaler_pkg::A_BLK_EN;
  wire        wr_hw    = wr && addr == scaler_pkg::A_HW_EN;
  wire        wr_gate  = wr && addr == scaler_pkg::A_ACQ_GATE;
  wire        wr_out   = wr && addr[7:4] == scaler_pkg::A_OUTSEL0[7:4] && addr[1:0] == 2'h0;
  wire        in_hit   = addr[7:5] == scaler_pkg::A_INSEL0[7:5] && addr[4:2] != 3'h7 && addr[1:0] == 2'h0;
  wire        wr_in    = wr && in_hit;
  wire [2:0]  in_idx   = addr[4:2];
  wire [31:0] status_w = {lcl_cnt_reg, 13'h0000, st_reg, module_busy_reg};
  wire [31:0] rd_mux =
      (addr == scaler_pkg::A_BLK_EN)   ? {28'h0000000, blk_en_reg} :
      (addr == scaler_pkg::A_HW_EN)    ? {28'h0000000, hw_en_reg} :
      (addr == scaler_pkg::A_ACQ_GATE) ? {31'h00000000, acq_gate_reg} :
      (addr == scaler_pkg::A_STATUS)   ? status_w :
      (addr[7:4] == scaler_pkg::A_OUTSEL0[7:4] && addr[1:0] == 2'h0) ? {28'h0000000, outsel_reg[addr[3:2]]} :
      in_hit ?
        {29'h00000000, insel_reg[in_idx]} : 32'h00000000;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blk_en_reg   <= scaler_pkg::BLK_EN_RST;
      hw_en_reg    <= scaler_pkg::HW_EN_RST;
      acq_gate_reg <= 1'b0;
      sw_clr_reg   <= 1'b0;
      rdata_reg    <= 32'h00000000;
      for (int i = 0; i < 4; i++) outsel_reg[i] <= scaler_pkg::OUTSEL_RST[i*4 +: 4]; // R12
      for (int i = 0; i < 7; i++) insel_reg[i] <= scaler_pkg::INSEL_RST[i*3 +: 3];   // R12
    end else begin
      sw_clr_reg <= wr_clr; // R25
      rdata_reg  <= rd ? rd_mux : 32'h00000000;
      if (wr_blk) blk_en_reg <= wdata[3:0]; // R24
      if (wr_hw) hw_en_reg <= wdata[3:0];   // R24
      if (wr_gate) acq_gate_reg <= wdata[0];
      if (wr_out) outsel_reg[addr[3:2]] <= wdata[3:0];
      if (wr_in) insel_reg[in_idx] <= wdata[2:0];
    end
  end

  // Input routing: codes 0 to 3 pick a NIM input, code 7 the built-in default.
  function automatic logic pick_in(input logic [2:0] code, input logic [3:0] nim, input logic dflt);
    if (code <= 3'h3) return nim[code[1:0]]; // R11
    if (code == scaler_pkg::IN_DEFAULT) return dflt; // R11
    return 1'b0;
  endfunction : pick_in

  wire [6:0] dflt_in = {nim_in[3], nim_in[2], nim_in[1], 1'b1, 1'b0, 1'b0, nim_in[0]}; // R8 R12
  logic [6:0] routed_w;
  always_comb begin
    for (int i = 0; i < 7; i++) routed_w[i] = pick_in(insel_reg[i], nim_in, dflt_in[i]);
  end

  wire gate_w    = routed_reg[scaler_pkg::IN_GATE];
  wire ext_cclr  = routed_reg[scaler_pkg::IN_CCLR];
  wire l1_w      = routed_reg[scaler_pkg::IN_L1] | rx_info.level1;
  wire l1_take   = l1_w && !l1_prev_reg && st_reg == scaler_pkg::ST_IDLE;
  wire [3:0] blk_clr = {4{sw_clr_reg}} | ({4{ext_cclr}} & hw_en_reg); // R4 R5

  // Channel counters; each wraps by plain modulo arithmetic.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= hit_in;    // R1
      sync2_reg <= sync1_reg; // R1
      sync3_reg <= sync2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire inc = sync2_reg[g] && !sync3_reg[g] && blk_en_reg[g/32] && gate_w; // R1 R3 R7
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cnt_reg[g]  <= 28'h0000000;
          snap_reg[g] <= 28'h0000000;
        end else begin
          if (blk_clr[g/32]) cnt_reg[g] <= 28'h0000000; // R4 R5
          else if (inc) cnt_reg[g] <= cnt_reg[g] + 28'h0000001; // R1 R2
          if (l1_take) snap_reg[g] <= cnt_reg[g]; // R23
        end
      end
    end
  endgenerate

  // First enabled block at or after the given one; bit 2 set means none.
  function automatic logic [2:0] first_blk(input logic [3:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h4;
    for (int i = 3; i >= 0; i--) if (en[i] && 3'(i) >= from) r = 3'(i);
    return r;
  endfunction : first_blk

  wire [31:0] hdr2_w = {scaler_pkg::HDR_MARK, 8'h00, 5'h00, nwords_reg}; // R15
  wire [31:0] hdr3_w = {scaler_pkg::HDR_MARK, present_reg, 3'h0,
                        rx_lat_reg.spill_num[0], rx_lat_reg.event_num[2:0], lcl_cnt_reg}; // R16 R17
  wire [31:0] recv_w = {scaler_pkg::RECV_MARK, 2'h0, 1'b1, rx_lat_reg.spill_inc,
                        rx_lat_reg.spill_num, rx_lat_reg.event_num}; // R19
  wire [31:0] cnt_w  = {scaler_pkg::BLOCK_CODE0 + {2'h0, ch_reg[6:5]}, snap_reg[ch_reg]}; // R20 R21
  wire [31:0] cur_w  = (st_reg == scaler_pkg::ST_HEAD) ?
                         ((hd_reg == 2'h0) ? scaler_pkg::MAGIC_WORD : (hd_reg == 2'h1) ? hdr2_w : hdr3_w) : // R14
                       (st_reg == scaler_pkg::ST_RECV) ? recv_w : cnt_w;
  wire        advance = !evt_reg.valid || evt_ready;
  wire [2:0]  blk0    = first_blk(en_lat_reg, 3'h0);
  wire [2:0]  blk_nx  = first_blk(en_lat_reg, {1'b0, ch_reg[6:5]} + 3'h1);
  // Counted from the live enables, since the latched copy only loads on the same edge.
  wire [2:0]  en_cnt  = 3'(blk_en_reg[0]) + 3'(blk_en_reg[1]) + 3'(blk_en_reg[2]) + 3'(blk_en_reg[3]);

  wire evt_done_w = (st_reg == scaler_pkg::ST_HEAD && hd_reg == 2'h2 && !present_reg && blk0[2]) ||
                    (st_reg == scaler_pkg::ST_RECV && blk0[2]) ||
                    (st_reg == scaler_pkg::ST_CNT && ch_reg[4:0] == 5'h1F && blk_nx[2]);

  // Event builder: a trigger is taken only when the previous event is out.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= scaler_pkg::ST_IDLE;
      hd_reg      <= 2'h0;
      ch_reg      <= 7'h00;
      evt_reg     <= '0;
      en_lat_reg  <= 4'h0;
      rx_lat_reg  <= '0;
      present_reg <= 1'b0;
      nwords_reg  <= 11'h000;
      lcl_cnt_reg <= 16'h0000;
    end else begin
      if (advance && st_reg == scaler_pkg::ST_IDLE) evt_reg.valid <= 1'b0;
      if (l1_take) begin
        st_reg      <= scaler_pkg::ST_HEAD;
        hd_reg      <= 2'h0;
        en_lat_reg  <= blk_en_reg;
        rx_lat_reg  <= rx_info;
        present_reg <= switch_in[1]; // R22
        nwords_reg  <= {3'h0, en_cnt, 5'h00} + {10'h000, switch_in[1]}; // R15 R22
      end else if (advance && st_reg != scaler_pkg::ST_IDLE) begin
        evt_reg.valid <= 1'b1;
        evt_reg.data  <= cur_w;
        unique case (st_reg)
          scaler_pkg::ST_HEAD: begin
            hd_reg <= hd_reg + 2'h1;
            if (hd_reg == 2'h2) begin
              if (present_reg) st_reg <= scaler_pkg::ST_RECV; // R22
              else if (blk0[2]) st_reg <= scaler_pkg::ST_IDLE;
              else st_reg <= scaler_pkg::ST_CNT;
              ch_reg <= {blk0[1:0], 5'h00};
            end
          end
          scaler_pkg::ST_RECV: begin
            st_reg <= blk0[2] ? scaler_pkg::ST_IDLE : scaler_pkg::ST_CNT;
            ch_reg <= {blk0[1:0], 5'h00};
          end
          scaler_pkg::ST_CNT: begin
            if (ch_reg[4:0] != 5'h1F) ch_reg <= ch_reg + 7'h01; // R20
            else if (blk_nx[2]) st_reg <= scaler_pkg::ST_IDLE;
            else ch_reg <= {blk_nx[1:0], 5'h00};
          end
          default: st_reg <= scaler_pkg::ST_IDLE;
        endcase
      end
      if (advance && st_reg != scaler_pkg::ST_IDLE && !l1_take && evt_done_w) lcl_cnt_reg <= lcl_cnt_reg + 16'h0001; // R18
    end
  end

  // Reference clocks from a 1 us prescaler and three decade stages.
  wire pres_wrap = pres_reg == 8'(scaler_pkg::PRESCALE - 1);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pres_reg <= 8'h00;
      for (int i = 0; i < 3; i++) dec_reg[i] <= 4'h0;
    end else begin
      pres_reg <= pres_wrap ? 8'h00 : pres_reg + 8'h01;
      if (pres_wrap) dec_reg[0] <= (dec_reg[0] == 4'h9) ? 4'h0 : dec_reg[0] + 4'h1;
      if (pres_wrap && dec_reg[0] == 4'h9) dec_reg[1] <= (dec_reg[1] == 4'h9) ? 4'h0 : dec_reg[1] + 4'h1;
      if (pres_wrap && dec_reg[0] == 4'h9 && dec_reg[1] == 4'h9)
        dec_reg[2] <= (dec_reg[2] == 4'h9) ? 4'h0 : dec_reg[2] + 4'h1;
    end
  end

  wire [15:0] out_src = {3'h0, dec_reg[2] < 4'h5, dec_reg[1] < 4'h5, dec_reg[0] < 4'h5,
                         pres_reg < 8'(scaler_pkg::PRESCALE / 2), switch_in[7], acq_gate_reg,
                         rx_info.spill_inc, rx_info.spare1, rx_info.clear, rx_info.level2, rx_info.level1,
                         crate_busy_reg, module_busy_reg}; // R9
  logic [3:0] nim_w;
  always_comb begin
    for (int i = 0; i < 4; i++) nim_w[i] = out_src[outsel_reg[i]]; // R9
  end

  // Busy and routed signals.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      routed_reg      <= 7'h00;
      l1_prev_reg     <= 1'b0;
      busy_cnt_reg    <= 8'h00;
      self_busy_reg   <= 1'b0;
      module_busy_reg <= 1'b0;
      crate_busy_reg  <= 1'b0;
      nim_out_reg     <= 4'h0;
    end else begin
      routed_reg      <= routed_w;
      l1_prev_reg     <= l1_w;
      if (l1_take) busy_cnt_reg <= 8'(DLY - 1); // R13
      else if (busy_cnt_reg != 8'h00) busy_cnt_reg <= busy_cnt_reg - 8'h01;
      self_busy_reg   <= l1_take || busy_cnt_reg != 8'h00; // R13
      module_busy_reg <= l1_take || busy_cnt_reg != 8'h00 || st_reg != scaler_pkg::ST_IDLE;
      crate_busy_reg  <= module_busy_reg | backplane_busy | routed_reg[scaler_pkg::IN_BUSY]; // R10
      nim_out_reg     <= nim_w;
    end
  end

  assign rdata       = rdata_reg;
  assign evt_out     = evt_reg;
  assign nim_out     = nim_out_reg;
  assign route_out   = {routed_reg[scaler_pkg::IN_SPARE], routed_reg[scaler_pkg::IN_CLR], routed_reg[scaler_pkg::IN_L2]};
  assign module_busy = module_busy_reg;

  // The self-busy window is checked high for its first 8 cycles after a trigger and low once its fixed length ends.
  property p_self_busy;
    @(posedge clk_sys) disable iff (!nrst) l1_take |=> self_busy_reg [*8] ##BUSY_TAIL (!self_busy_reg || l1_take);
  endproperty
  a_self_busy: assert property (p_self_busy) else $error("self busy length wrong"); // R13

  property p_count_inc;
    @(posedge clk_sys) disable iff (!nrst)
      g_ch[0].inc && !blk_clr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 28'h0000001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not step by one"); // R1 R2

  property p_gate_hold;
    @(posedge clk_sys) disable iff (!nrst) !gate_w && !blk_clr[0] |=> $stable(cnt_reg[0]);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counter moved with gate low"); // R7

  property p_blk_off;
    @(posedge clk_sys) disable iff (!nrst) !blk_en_reg[1] && !blk_clr[1] |=> $stable(cnt_reg[32]);
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("disabled block counted"); // R3

  property p_sw_clear;
    @(posedge clk_sys) disable iff (!nrst) wr_clr |=> sw_clr_reg ##1 cnt_reg[0] == 28'h0 && !sw_clr_reg;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear failed"); // R4 R25

  property p_hw_mask;
    @(posedge clk_sys) disable iff (!nrst)
      ext_cclr && !hw_en_reg[0] && !sw_clr_reg && !g_ch[0].inc |=> $stable(cnt_reg[0]);
  endproperty
  a_hw_mask: assert property (p_hw_mask) else $error("masked hardware clear acted"); // R5

  property p_magic;
    @(posedge clk_sys) disable iff (!nrst) l1_take && advance |=> ##1 evt_reg.data == scaler_pkg::MAGIC_WORD;
  endproperty
  a_magic: assert property (p_magic) else $error("first header word wrong"); // R14

  property p_crate;
    @(posedge clk_sys) disable iff (!nrst)
      backplane_busy && outsel_reg[0] == 4'h1 && $stable(outsel_reg[0]) && !wr_out |=> ##1 nim_out_reg[0];
  endproperty
  a_crate: assert property (p_crate) else $error("crate busy missing backplane busy"); // R10

  property p_lcl_cnt;
    @(posedge clk_sys) disable iff (!nrst) $changed(lcl_cnt_reg) |-> $past(st_reg) != scaler_pkg::ST_IDLE;
  endproperty
  a_lcl_cnt: assert property (p_lcl_cnt) else $error("event counter moved without forwarding"); // R18

  c_event:  cover property (@(posedge clk_sys) disable iff (!nrst) l1_take ##[1:300] st_reg == scaler_pkg::ST_IDLE);
  c_wrap:   cover property (@(posedge clk_sys) disable iff (!nrst) cnt_reg[0] == 28'hFFFFFFF ##1 cnt_reg[0] == 28'h0);
  c_recv:   cover property (@(posedge clk_sys) disable iff (!nrst) st_reg == scaler_pkg::ST_RECV);
  c_hwclr:  cover property (@(posedge clk_sys) disable iff (!nrst) ext_cclr && hw_en_reg[0]);
endmodule : scaler_top

// ### scaler_partner.sv
`timescale 1ns/1ps
module scaler_partner (
  input  wire logic                  clk_sys,   // System clock.
  input  wire logic                  stall,     // Sink accepts only every other cycle.
  input  wire scaler_pkg::evt_word_s evt_out,   // Event word stream.
  output logic                       evt_ready, // Sink accepts word.
  output logic [127:0]               hit_in     // Detector pulses.
);
  logic [31:0] words[$];
  logic        phase_reg;

  initial begin
    hit_in = '0;
    phase_reg = 1'h0;
  end

  // A slow sink proves that each word holds until it is taken.
  assign evt_ready = !stall || phase_reg;

  always @(posedge clk_sys) begin
    phase_reg <= !phase_reg;
    if (evt_out.valid === 1'h1 && evt_ready) begin
      words.push_back(evt_out.data);
    end
  end

  // Two cycles high and two low keep each pulse above the minimum width.
  task automatic pulse(input logic [127:0] mask, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      hit_in <= mask;
      repeat (2) @(posedge clk_sys);
      hit_in <= '0;
      @(posedge clk_sys);
    end
  endtask : pulse
endmodule : scaler_partner

// ### tb_multichannel_scaler_daq.sv
`timescale 1ns/1ps
module tb_multichannel_scaler_daq;
  logic                  clk_sys, nrst, wr, rd, backplane_busy, evt_ready, stall, module_busy;
  logic [7:0]            addr, switch_in;
  logic [31:0]           wdata, rdata;
  logic [127:0]          hit_in;
  logic [3:0]            nim_in, nim_out;
  logic [2:0]            route_out;
  scaler_pkg::rx_info_s  rx_info;
  scaler_pkg::evt_word_s evt_out;
  int                    bad_count, comparisons, lcl, busy_n, j;
  int                    exp_cnt[128];
  localparam logic [39:0] RST_TAB[13] = '{40'h040000000F, 40'h080000000F, 40'h1000000000, 40'h1400000007,
    40'h180000000C, 40'h1C00000008, 40'h2000000000, 40'h2400000007, 40'h2C00000007, 40'h3000000001,
    40'h3400000002, 40'h3800000003, 40'h4000000000};
  localparam logic [6:0] OUT_TAB[8] = '{7'h1A, 7'h10, 7'h43, 7'h40, 7'h6E, 7'h0D, 7'h39, 7'h31};

  scaler_top #(.NCH(128)) u_scaler_top (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .hit_in(hit_in), .nim_in(nim_in), .switch_in(switch_in),
    .backplane_busy(backplane_busy), .rx_info(rx_info), .evt_ready(evt_ready), .evt_out(evt_out),
    .nim_out(nim_out), .route_out(route_out), .module_busy(module_busy));
  scaler_partner u_scaler_partner (.clk_sys(clk_sys), .stall(stall), .evt_out(evt_out), .evt_ready(evt_ready),
    .hit_in(hit_in));

  always #2 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk_sys);
    wr    <= 1'h0;
  endtask : reg_write

  task automatic check_reg(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk_sys);
    rd   <= 1'h0;
    @(negedge clk_sys);
    check(rdata, want);
  endtask : check_reg

  // Expected words come from the counts the bench itself has sent.
  task automatic trigger_check(input logic [3:0] blk, input logic rx);
    logic [31:0] w[$];
    int          n, k, t;
    n = rx;
    t = 0;
    busy_n = 0;
    for (k = 0; k < 4; k++) begin
      n += blk[k] ? 32 : 0;
    end
    @(posedge clk_sys);
    rx_info.level1 <= 1'h1;
    @(posedge clk_sys);
    rx_info.level1 <= 1'h0;
    while ((u_scaler_partner.words.size() < n + 3 || module_busy !== 1'h0) && t < 3000) begin
      @(negedge clk_sys);
      t++;
      if (module_busy === 1'h1) begin
        busy_n++;
      end
    end
    if (t == 3000) begin
      bad_count++;
      give_verdict();
    end
    w = u_scaler_partner.words;
    u_scaler_partner.words.delete();
    check(32'(w.size()), 32'(n + 3));
    check(w[0], scaler_pkg::MAGIC_WORD);
    check(w[1], {8'hFF, 8'h00, 5'h0, 11'(n)});
    check(w[2], {8'hFF, rx, 3'h0, rx_info.spill_num[0], rx_info.event_num[2:0], 16'(lcl)});
    k = 3;
    if (rx) begin
      check(w[3], {8'hF9, 2'h0, 1'h1, rx_info.spill_inc, rx_info.spill_num, rx_info.event_num});
      k = 4;
    end
    for (int b = 0; b < 4; b++) begin
      for (int c = 0; c < 32 && blk[b]; c++) begin
        check(w[k], {4'h8 + 4'(b), 28'(exp_cnt[b * 32 + c])});
        k++;
      end
    end
    lcl++;
  endtask : trigger_check

  initial begin
    clk_sys = 1'h0;
    nrst = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    backplane_busy = 1'h0;
    stall = 1'h0;
    switch_in = 8'h00;
    nim_in = 4'h0;
    rx_info = '0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'h1;
    foreach (RST_TAB[j]) check_reg(RST_TAB[j][39:32], RST_TAB[j][31:0]);
    $display("test reset_values done");

    u_scaler_partner.pulse({94'h0, 2'h2, 32'h1}, 1);
    u_scaler_partner.pulse({1'h1, 127'h1}, 2);
    exp_cnt[0] = 3;
    exp_cnt[33] = 1;
    exp_cnt[127] = 2;
    trigger_check(4'hF, 1'h0);
    $display("test counting done");

    reg_write(8'h04, 32'hD);
    reg_write(8'h2C, 32'h3);
    u_scaler_partner.pulse({95'h0, 1'h1, 32'h1}, 1);
    nim_in <= 4'h8;
    repeat (3) @(negedge clk_sys);
    check({29'h0, route_out}, 32'h4);
    u_scaler_partner.pulse({95'h0, 1'h1, 32'h0}, 1);
    u_scaler_partner.pulse(128'h1, 1);
    exp_cnt[0] = 4;
    reg_write(8'h2C, 32'h7);
    trigger_check(4'hD, 1'h0);
    reg_write(8'h04, 32'hF);
    $display("test enable_and_gate done");

    reg_write(8'h08, 32'h1);
    @(posedge clk_sys);
    nim_in <= 4'hA;
    repeat (2) @(posedge clk_sys);
    nim_in <= 4'h8;
    exp_cnt[0] = 0;
    repeat (30) @(posedge clk_sys);
    switch_in <= 8'h02;
    stall <= 1'h1;
    rx_info.event_num <= 12'hABD;
    rx_info.spill_num <= 8'h35;
    rx_info.spill_inc <= 1'h1;
    trigger_check(4'hF, 1'h1);
    $display("test hw_clear_and_receiver done");

    reg_write(8'h00, 32'h0);
    exp_cnt[33] = 0;
    exp_cnt[127] = 0;
    repeat (30) @(posedge clk_sys);
    trigger_check(4'hF, 1'h1);
    $display("test sw_clear done");

    reg_write(8'h04, 32'h0);
    switch_in <= 8'h00;
    trigger_check(4'h0, 1'h0);
    check(32'(busy_n >= 53 && busy_n <= 56), 32'h1);
    $display("test self_busy done");

    reg_write(8'h0C, 32'h1);
    foreach (OUT_TAB[j]) begin
      reg_write(8'h10, {28'h0, OUT_TAB[j][6:3]});
      backplane_busy <= OUT_TAB[j][2];
      switch_in <= {OUT_TAB[j][1], 7'h02};
      repeat (4) @(negedge clk_sys);
      check({31'h0, nim_out[0]}, {31'h0, OUT_TAB[j][0]});
    end
    $display("test output_select done");
    give_verdict();
  end
endmodule : tb_multichannel_scaler_daq
